// file: hw/mem_xfer_pkg.sv
// constants for the memory load/store execution block
package mem_xfer_pkg;
    localparam logic [7:0] OP_LOAD_IND      = 8'hc3; // r <- (pointer pair)
    localparam logic [7:0] OP_STORE_IND     = 8'hd3; // (pointer pair) <- r
    localparam logic [7:0] OP_LOAD_SHORT    = 8'he7; // r <- (short disp + pair)
    localparam logic [7:0] OP_STORE_SHORT   = 8'hf7;
    localparam logic [7:0] OP_LOAD_LONG     = 8'ha7; // long disp or direct address
    localparam logic [7:0] OP_STORE_LONG    = 8'hb7;
    localparam logic [7:0] OP_LOAD_POST_DEC = 8'he2;
    localparam logic [7:0] OP_LOAD_POST_INC = 8'he3;
    localparam logic [7:0] OP_STORE_PRE_DEC = 8'hf2;
    localparam logic [7:0] OP_STORE_PRE_INC = 8'hf3;
    localparam logic [3:0] NIB_ZERO         = 4'h0;
    localparam logic [3:0] NIB_DIRECT_PROG  = 4'h0; // direct form, program space
    localparam logic [3:0] NIB_DIRECT_DATA  = 4'h1; // direct form, data space
    localparam logic [15:0] PTR_STEP        = 16'h0001;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;
    // execution state codes, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_OPND  = 7'b0000010,
        ST_DISP0 = 7'b0000100,
        ST_DISP1 = 7'b0001000,
        ST_PRE   = 7'b0010000,
        ST_MEM   = 7'b0100000,
        ST_POST  = 7'b1000000
    } exec_state_t;
    // pointer update kind
    typedef enum logic [3:0] {
        UPD_NONE = 4'b0001,
        UPD_DEC  = 4'b0010,
        UPD_INC  = 4'b0100,
        UPD_HOLD = 4'b1000
    } ptr_upd_t;
endpackage

// file: hw/memory_load_store_exec.sv
// execution unit for byte moves between working registers and program/data memory
//////////////////////////////////////////////////////////////////////////////////
module memory_load_store_exec
    import mem_xfer_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // instruction byte stream from fetch
    input  wire logic        instValid,
    input  wire logic [7:0]  instByte,
    output logic             instTake,
    // working register file port
    output logic [3:0]       regAddr,
    output logic             regRead,
    input  wire logic [7:0]  regRdata,
    output logic             regWrite,
    output logic [7:0]       regWdata,
    // memory port
    output logic             memReq,
    output logic             memWrite,
    output logic             memProg,
    output logic [15:0]      memAddr,
    output logic [7:0]       memWdata,
    input  wire logic        memAck,
    input  wire logic [7:0]  memRdata,
    // status back to the core
    output logic             execBusy,
    output logic             execDone,
    output logic             execRefused
);
    exec_state_t state_r, state_nxt;
    ptr_upd_t    upd_r, upd_nxt;
    logic [7:0]  opc_r, opc_nxt;
    logic [3:0]  dataReg_r, dataReg_nxt;
    logic [3:0]  pairIdx_r, pairIdx_nxt;
    logic [15:0] disp_r, disp_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic        isStore_r, isStore_nxt;
    logic        isDirect_r, isDirect_nxt;
    logic [2:0]  dispLeft_r, dispLeft_nxt;
    logic [2:0]  ptrStep_r, ptrStep_nxt;
    logic        instTake_nxt, regRead_nxt, regWrite_nxt, memReq_nxt, memWrite_nxt;
    logic        memProg_nxt, execDone_nxt, execRefused_nxt;
    logic [3:0]  regAddr_nxt;
    logic [7:0]  regWdata_nxt, memWdata_nxt;
    logic [15:0] memAddr_nxt;
    logic        knownOp;
    logic        isIndexed;
    logic        isLong;

    //////////////////////////////////////////////////////////////////////////////
    // opcode classification
    always_comb begin
        knownOp = (instByte == OP_LOAD_IND) || (instByte == OP_STORE_IND) ||
                  (instByte == OP_LOAD_SHORT) || (instByte == OP_STORE_SHORT) ||
                  (instByte == OP_LOAD_LONG) || (instByte == OP_STORE_LONG) ||
                  (instByte == OP_LOAD_POST_DEC) || (instByte == OP_LOAD_POST_INC) ||
                  (instByte == OP_STORE_PRE_DEC) || (instByte == OP_STORE_PRE_INC);
        isIndexed = (opc_r == OP_LOAD_SHORT) || (opc_r == OP_STORE_SHORT) ||
                    (opc_r == OP_LOAD_LONG) || (opc_r == OP_STORE_LONG);
        isLong = (opc_r == OP_LOAD_LONG) || (opc_r == OP_STORE_LONG);
    end

    //////////////////////////////////////////////////////////////////////////////
    // sequencer next state; the pair comes in as two byte reads (even high, odd low)
    always_comb begin
        state_nxt       = state_r;
        upd_nxt         = upd_r;
        opc_nxt         = opc_r;
        dataReg_nxt     = dataReg_r;
        pairIdx_nxt     = pairIdx_r;
        disp_nxt        = disp_r;
        ptr_nxt         = ptr_r;
        isStore_nxt     = isStore_r;
        isDirect_nxt    = isDirect_r;
        dispLeft_nxt    = dispLeft_r;
        ptrStep_nxt     = ptrStep_r;
        instTake_nxt    = 1'b0;
        regRead_nxt     = 1'b0;
        regWrite_nxt    = 1'b0;
        regAddr_nxt     = regAddr;
        regWdata_nxt    = regWdata;
        memReq_nxt      = memReq;
        memWrite_nxt    = memWrite;
        memProg_nxt     = memProg;
        memAddr_nxt     = memAddr;
        memWdata_nxt    = memWdata;
        execDone_nxt    = 1'b0;
        execRefused_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (instValid && knownOp) begin
                    opc_nxt      = instByte;
                    instTake_nxt = 1'b1;
                    isStore_nxt  = (instByte == OP_STORE_IND) || (instByte == OP_STORE_SHORT) ||
                                   (instByte == OP_STORE_LONG) ||
                                   (instByte == OP_STORE_PRE_DEC) ||
                                   (instByte == OP_STORE_PRE_INC);
                    unique case (instByte)
                        OP_LOAD_POST_DEC: upd_nxt = UPD_DEC;
                        OP_LOAD_POST_INC: upd_nxt = UPD_INC;
                        OP_STORE_PRE_DEC: upd_nxt = UPD_DEC;
                        OP_STORE_PRE_INC: upd_nxt = UPD_INC;
                        default:          upd_nxt = UPD_NONE;
                    endcase
                    state_nxt = ST_OPND;
                end
            end
            ST_OPND: begin
                // operand byte: high nibble data register, low nibble pair index
                if (instValid && !instTake) begin
                    instTake_nxt = 1'b1;
                    dataReg_nxt  = instByte[7:4];
                    pairIdx_nxt  = instByte[3:0];
                    // direct form: pair field zero (program) or one (data)
                    isDirect_nxt = isLong && (instByte[3:1] == NIB_ZERO[2:0]);
                    disp_nxt     = WORD_ZERO;
                    dispLeft_nxt = (opc_r == OP_LOAD_SHORT || opc_r == OP_STORE_SHORT) ?
                                   3'd1 : (isLong ? 3'd2 : 3'd0);
                    ptrStep_nxt  = 3'd0;
                    state_nxt    = isIndexed ? ST_DISP0 : ST_PRE;
                end
            end
            ST_DISP0: begin
                if (instValid && !instTake) begin
                    instTake_nxt = 1'b1;
                    if (dispLeft_r == 3'd1) begin
                        disp_nxt  = {BYTE_ZERO, instByte};
                        state_nxt = ST_PRE;
                    end else begin
                        disp_nxt  = {instByte, BYTE_ZERO};  // high byte first
                        state_nxt = ST_DISP1;
                    end
                end
            end
            ST_DISP1: begin
                if (instValid && !instTake) begin
                    instTake_nxt = 1'b1;
                    disp_nxt     = {disp_r[15:8], instByte};
                    state_nxt    = ST_PRE;
                end
            end
            ST_PRE: begin
                // three back-to-back reads; each byte lands a cycle after its address
                ptrStep_nxt = ptrStep_r + 3'd1;
                regRead_nxt = (ptrStep_r < 3'd3);
                unique case (ptrStep_r)
                    3'd0: regAddr_nxt = {pairIdx_r[3:1], 1'b0};
                    3'd1: regAddr_nxt = {pairIdx_r[3:1], 1'b1};
                    3'd2: begin
                        regAddr_nxt   = dataReg_r;
                        ptr_nxt[15:8] = regRdata;
                    end
                    3'd3: ptr_nxt[7:0] = regRdata;
                    default: begin
                        // pair complete, data register byte on the port now
                        ptrStep_nxt  = ptrStep_r;
                        state_nxt    = ST_MEM;
                        memProg_nxt  = isDirect_r ? (pairIdx_r[0] == NIB_DIRECT_PROG[0]) :
                                                    !pairIdx_r[0];
                        memWrite_nxt = isStore_r;
                        memWdata_nxt = regRdata;
                        if (isDirect_r)
                            memAddr_nxt = disp_r;
                        else if (isStore_r && upd_r == UPD_DEC)
                            memAddr_nxt = ptr_r - PTR_STEP;
                        else if (isStore_r && upd_r == UPD_INC)
                            memAddr_nxt = ptr_r + PTR_STEP;
                        else
                            memAddr_nxt = ptr_r + disp_r;
                        if (isStore_r && memProg_nxt && MASK_ROM) begin
                            execRefused_nxt = 1'b1;
                            execDone_nxt    = 1'b1;
                            state_nxt       = ST_IDLE;
                        end else begin
                            memReq_nxt = 1'b1;
                        end
                    end
                endcase
            end
            ST_MEM: begin
                if (memAck) begin
                    memReq_nxt   = 1'b0;
                    memWrite_nxt = 1'b0;
                    // loads write the destination register here; source memory is untouched
                    if (!isStore_r) begin
                        regWrite_nxt = 1'b1;
                        regAddr_nxt  = dataReg_r;
                        regWdata_nxt = memRdata;
                    end
                    ptr_nxt   = memAddr;
                    if (upd_r == UPD_DEC && !isStore_r)
                        ptr_nxt = ptr_r - PTR_STEP;
                    else if (upd_r == UPD_INC && !isStore_r)
                        ptr_nxt = ptr_r + PTR_STEP;
                    state_nxt = (upd_r == UPD_NONE) ? ST_IDLE : ST_POST;
                    execDone_nxt = (upd_r == UPD_NONE);
                end
            end
            ST_POST: begin
                // write back updated pair: high byte then low byte
                regWrite_nxt = 1'b1;
                if (upd_r != UPD_HOLD) begin
                    regAddr_nxt  = {pairIdx_r[3:1], 1'b0};
                    regWdata_nxt = ptr_r[15:8];
                    upd_nxt      = UPD_HOLD;
                end else begin
                    regAddr_nxt  = {pairIdx_r[3:1], 1'b1};
                    regWdata_nxt = ptr_r[7:0];
                    upd_nxt      = UPD_NONE;
                    execDone_nxt = 1'b1;
                    state_nxt    = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // registers; no flag output exists, so flags cannot change
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            upd_r       <= UPD_NONE;
            opc_r       <= BYTE_ZERO;
            dataReg_r   <= NIB_ZERO;
            pairIdx_r   <= NIB_ZERO;
            disp_r      <= WORD_ZERO;
            ptr_r       <= WORD_ZERO;
            isStore_r   <= 1'b0;
            isDirect_r  <= 1'b0;
            dispLeft_r  <= 3'd0;
            ptrStep_r   <= 3'd0;
            instTake    <= 1'b0;
            regAddr     <= NIB_ZERO;
            regRead     <= 1'b0;
            regWrite    <= 1'b0;
            regWdata    <= BYTE_ZERO;
            memReq      <= 1'b0;
            memWrite    <= 1'b0;
            memProg     <= 1'b0;
            memAddr     <= WORD_ZERO;
            memWdata    <= BYTE_ZERO;
            execBusy    <= 1'b0;
            execDone    <= 1'b0;
            execRefused <= 1'b0;
        end else if (clkEn) begin
            state_r     <= state_nxt;
            upd_r       <= upd_nxt;
            opc_r       <= opc_nxt;
            dataReg_r   <= dataReg_nxt;
            pairIdx_r   <= pairIdx_nxt;
            disp_r      <= disp_nxt;
            ptr_r       <= ptr_nxt;
            isStore_r   <= isStore_nxt;
            isDirect_r  <= isDirect_nxt;
            dispLeft_r  <= dispLeft_nxt;
            ptrStep_r   <= ptrStep_nxt;
            instTake    <= instTake_nxt;
            regAddr     <= regAddr_nxt;
            regRead     <= regRead_nxt;
            regWrite    <= regWrite_nxt;
            regWdata    <= regWdata_nxt;
            memReq      <= memReq_nxt;
            memWrite    <= memWrite_nxt;
            memProg     <= memProg_nxt;
            memAddr     <= memAddr_nxt;
            memWdata    <= memWdata_nxt;
            execBusy    <= (state_nxt != ST_IDLE);
            execDone    <= execDone_nxt;
            execRefused <= execRefused_nxt;
        end
    end
endmodule

// file: tb/mem_xfer_props.sv
// port checker for the memory load/store execution unit
module mem_xfer_props
    import mem_xfer_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        instValid,
    input  wire logic [7:0]  instByte,
    input  wire logic        instTake,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic        memProg,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    input  wire logic        memAck,
    input  wire logic        execBusy,
    input  wire logic        execDone,
    input  wire logic        execRefused
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // a pending request keeps every qualifier frozen until the answer edge
    sequence s_wait;
        memReq && !memAck;
    endsequence
    sequence s_frozen;
        memReq && $stable(memAddr) && $stable(memWrite) && $stable(memProg) && $stable(memWdata);
    endsequence
    a_req_stands: assert property (s_wait |=> s_frozen) else $error("req moved");
    a_done_pulse: assert property (execDone |=> !execDone) else $error("done long");
    a_refuse_rom: assert property (execRefused |-> execDone && MASK_ROM) else $error("bad refuse");
    a_rom_store: assert property (memReq && memWrite && memProg |-> !MASK_ROM) else $error("rom st");
    a_take_pulse: assert property (instTake |=> !instTake) else $error("take long");
    a_take_valid: assert property (instTake |-> $past(instValid)) else $error("take no valid");
    // only the ten known opcodes are taken from idle
    a_unknown_op: assert property (!execBusy && !instTake && instValid &&
        !(instByte inside {8'hc3, 8'hd3, 8'he7, 8'hf7, 8'ha7, 8'hb7, 8'he2, 8'he3, 8'hf2, 8'hf3})
        |=> !instTake) else $error("unknown taken");
    a_ack_done: assert property (memReq && memAck |-> ##[0:3] execDone) else $error("no done");
    a_req_busy: assert property (memReq |-> execBusy) else $error("req idle");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !memReq && !execBusy)
        else $error("reset busy");
endmodule
bind memory_load_store_exec mem_xfer_props #(.MASK_ROM(MASK_ROM)) i_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .instValid(instValid), .instByte(instByte),
    .instTake(instTake), .memReq(memReq), .memWrite(memWrite), .memProg(memProg),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .execBusy(execBusy),
    .execDone(execDone), .execRefused(execRefused)
);

// file: tb/mem_model.sv
// behavioural memory spaces and working register file facing the unit
module mem_model
    import mem_xfer_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [3:0]  regAddr,
    input  wire logic        regRead,
    output logic [7:0]       regRdata,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWdata,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic        memProg,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    output logic             memAck,
    output logic [7:0]       memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  regs [16];
    logic [1:0]  waitCnt;
    logic [15:0] lastAddr;
    logic [7:0]  lastData;
    logic        lastProg;
    int          wrCount;
    initial begin
        regRdata = 8'h00;
        memRdata = 8'h00;
        memAck = 1'b0;
        waitCnt = 2'h0;
        wrCount = 0;
    end
    // register file, one cycle read latency; an idle port toggles so no stale byte passes
    always @(posedge sys_clk) begin
        regRdata <= regRead ? regs[regAddr] : ~regRdata;
        if (regWrite) begin
            regs[regAddr] <= regWdata;
        end
    end
    // memory answers after a random stall of up to three cycles, ack lasts one cycle
    always @(posedge sys_clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReq && !memAck && waitCnt != 2'h0) begin
            waitCnt <= waitCnt - 2'h1;
        end else if (memReq && !memAck) begin
            memAck <= 1'b1;
            waitCnt <= 2'($urandom_range(3));
            memRdata <= memAddr[7:0] ^ memAddr[15:8] ^ (memProg ? 8'h5a : 8'hc3);
            if (memWrite) begin
                wrCount <= wrCount + 1;
                lastAddr <= memAddr;
                lastProg <= memProg;
                lastData <= memWdata;
            end
        end
    end
endmodule

// file: tb/tb.sv
// self-checking bench for the memory load/store execution unit
module tb
    import mem_xfer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, instValid, instTake, regRead, regWrite, memReq, memWrite;
    logic        memProg, memAck, execBusy, execDone, execRefused;
    logic [7:0]  instByte, regRdata, regWdata, memWdata, memRdata;
    logic [3:0]  regAddr;
    logic [15:0] memAddr;
    int          n_fail, cmp_count;
    logic [7:0]  opTab [10] = '{OP_LOAD_IND, OP_STORE_IND, OP_LOAD_SHORT, OP_STORE_SHORT,
        OP_LOAD_LONG, OP_STORE_LONG, OP_LOAD_POST_DEC, OP_LOAD_POST_INC, OP_STORE_PRE_DEC,
        OP_STORE_PRE_INC};
    memory_load_store_exec i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .instValid(instValid),
        .instByte(instByte), .instTake(instTake), .regAddr(regAddr), .regRead(regRead),
        .regRdata(regRdata), .regWrite(regWrite), .regWdata(regWdata), .memReq(memReq),
        .memWrite(memWrite), .memProg(memProg), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata), .execBusy(execBusy), .execDone(execDone),
        .execRefused(execRefused)
    );
    mem_model i_mdl (
        .sys_clk(sys_clk), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata),
        .regWrite(regWrite), .regWdata(regWdata), .memReq(memReq), .memWrite(memWrite),
        .memProg(memProg), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait on a design flag; running out ends the run as a failure
    task automatic wait_hi(ref logic sig, input string what);
        for (int i = 0; i < 100; i++) begin
            @(posedge sys_clk);
            if (sig === 1'b1) return;
        end
        $display("Error %s expected 1 seen timeout", what);
        n_fail++;
        stop_test();
    endtask
    // a byte stays presented until the cycle that reports it consumed
    task automatic send(logic [7:0] b);
        instValid <= 1'b1;
        instByte <= b;
        wait_hi(instTake, "instTake");
    endtask
    function automatic logic [7:0] mval(logic prog, logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ (prog ? 8'h5a : 8'hc3);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // one instruction: preload registers, feed bytes, compare memory and registers
    task automatic run(logic [7:0] op, logic [3:0] dst, logic [3:0] p, logic [15:0] ptr,
                       logic [15:0] disp);
        logic [3:0]  hi;
        logic [3:0]  lo;
        logic [15:0] addr;
        logic [15:0] nptr;
        logic [7:0]  src;
        int          wc;
        logic        ld;
        hi = {p[3:1], 1'b0};
        lo = {p[3:1], 1'b1};
        src = 8'($urandom);
        i_mdl.regs[hi] = ptr[15:8];
        i_mdl.regs[lo] = ptr[7:0];
        i_mdl.regs[dst] = src;
        wc = i_mdl.wrCount;
        ld = !op[4]; // every store opcode has bit 4 set
        nptr = ptr;
        addr = ptr;
        case (op)
            OP_LOAD_SHORT, OP_STORE_SHORT: addr = ptr + {8'h00, disp[7:0]};
            OP_LOAD_LONG, OP_STORE_LONG: addr = (p[3:1] == 3'h0) ? disp : ptr + disp;
            OP_LOAD_POST_DEC, OP_STORE_PRE_DEC: nptr = ptr - 16'h0001;
            OP_LOAD_POST_INC, OP_STORE_PRE_INC: nptr = ptr + 16'h0001;
            default: ;
        endcase
        if (op == OP_STORE_PRE_DEC || op == OP_STORE_PRE_INC) addr = nptr;
        send(op);
        send({dst, p});
        if (op == OP_LOAD_LONG || op == OP_STORE_LONG) send(disp[15:8]);
        if (op[3:0] == 4'h7) send(disp[7:0]);
        instValid <= 1'b0;
        wait_hi(execDone, "execDone");
        check("refused", 16'(execRefused), 16'h0000);
        @(posedge sys_clk);
        check("writes", 16'(i_mdl.wrCount - wc), ld ? 16'h0000 : 16'h0001);
        if (ld) check("loaded", 16'(i_mdl.regs[dst]), 16'(mval(!p[0], addr)));
        else begin
            check("stAddr", i_mdl.lastAddr, addr);
            check("stProg", 16'(i_mdl.lastProg), 16'(!p[0]));
            check("stData", 16'(i_mdl.lastData), 16'(src));
            check("source", 16'(i_mdl.regs[dst]), 16'(src));
        end
        check("pointer", {i_mdl.regs[hi], i_mdl.regs[lo]}, nptr);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // main sequence: reset, unknown opcode, corner cases, random mix
    initial begin
        logic [3:0]  p;
        logic [7:0]  op;
        logic [15:0] disp;
        rst_n = 1'b0;
        instValid = 1'b0;
        instByte = 8'h00;
        n_fail = 0;
        cmp_count = 0;
        void'($urandom(32'h7740));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        instValid <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            check("untaken", 16'(instTake | execBusy), 16'h0000);
        end
        instValid <= 1'b0;
        $display("test unknown opcode done");
        run(OP_STORE_PRE_DEC, 4'h0, 4'h6, 16'h3000, 16'h0000);
        run(OP_STORE_PRE_INC, 4'h0, 4'h7, 16'h21ff, 16'h0000);
        run(OP_LOAD_POST_INC, 4'h8, 4'h6, 16'h00ff, 16'h0000);
        run(OP_LOAD_POST_DEC, 4'h0, 4'h9, 16'h0000, 16'h0000);
        run(OP_LOAD_LONG, 4'h8, 4'h0, 16'h0000, 16'h1104);
        run(OP_STORE_LONG, 4'h8, 4'h1, 16'h0000, 16'h1105);
        run(OP_LOAD_LONG, 4'h0, 4'h2, 16'h0104, 16'h1000);
        run(OP_LOAD_SHORT, 4'h0, 4'h3, 16'h0104, 16'h007f);
        $display("test corner cases done");
        for (int i = 0; i < 80; i++) begin
            op = opTab[$urandom_range(9)];
            p = 4'($urandom);
            // pair 0-1 in a long form is the literal address, never an index
            disp = (op[7:5] == 3'h5) ? 16'($urandom) : 16'($urandom_range(127));
            run(op, p ^ 4'h8, p, 16'($urandom), disp);
        end
        $display("test random mix done");
        stop_test();
    end
endmodule
